// ### fmrd_fault_mask.sv
`timescale 1ns/1ns
`default_nettype none
`include "fmrd_defines.svh"
// Function
// - Fault pin low for any unmasked status.
// - Thermal trip closes or opens all switches.
// - Bit 6 masks serial error summary.
// - Bit 4 masks all open detections.
// - Bit 3 masks all short detections.
// - Bit 2 masks pump not ready.
// - Bit 1 masks converter error.
// - Bit 0 masks thermal warning.
// - Per-LED mask hides that LED's faults from the pin only; the summaries still show them.
// - Done bit 4 set after decode.
// - Bit 3: address resistor high or open.
// - Bit 2: grade resistor high or open.
// - Bit 1: address resistor low or shorted.
// - Bit 0: grade resistor low or shorted.
// - Address code bits 7:4 sets identity.
// - Grade code in bits 3:0.
// - Converter error high until grade done.
// - Open summary is OR of opens.
module fmrd_fault_mask
  import fmrd_pkg::*;
#(
  parameter int N_LED = 12
) (
  input  wire logic                     i_clk,              // System clock, 50 MHz.
  input  wire logic                     i_rst,              // Asynchronous reset, active high.
  input  wire logic                     i_reg_wr,           // Register write strobe.
  input  wire logic                     i_reg_rd,           // Register read strobe.
  input  wire logic [`FMRD_ADDR_W-1:0]  i_reg_addr,         // Register address.
  input  wire logic [`FMRD_DATA_W-1:0]  i_reg_wdata,        // Register write data.
  input  wire logic                     i_thermal_warning,  // Latched thermal warning.
  input  wire logic                     i_thermal_trip,     // Latched thermal shutdown.
  input  wire logic                     i_pump_not_ready,   // Charge pump below threshold.
  input  wire logic                     i_serial_error,     // Serial error summary.
  input  wire logic [N_LED-1:0]         i_per_led_open,     // Per-LED open status.
  input  wire logic [N_LED-1:0]         i_per_led_short,    // Per-LED short status.
  input  wire logic [N_LED-1:0]         i_switch_cmd,       // Normal switch closed request.
  input  wire logic                     i_addr_valid,       // Pulse: address read done.
  input  wire logic [3:0]               i_addr_code,        // Decoded address resistor.
  input  wire logic                     i_addr_high,        // Address above range.
  input  wire logic                     i_addr_low,         // Address below range.
  input  wire logic                     i_grade_valid,      // Pulse: grade read done.
  input  wire logic [3:0]               i_grade_code,       // Decoded grade resistor.
  input  wire logic                     i_grade_high,       // Grade above range.
  input  wire logic                     i_grade_low,        // Grade below range.
  output logic [`FMRD_DATA_W-1:0]       o_reg_rdata,        // Read data, valid the cycle after i_reg_rd.
  output logic                          o_fault_out_n,      // Fault pin, active low.
  output logic [N_LED-1:0]              o_switch_closed,    // Bypass switch drive, 1 closes.
  output logic [3:0]                    o_node_identity,    // Serial device identity.
  output logic                          o_open_fault_summary,  // Any LED open.
  output logic                          o_short_fault_summary, // Any LED short.
  output logic                          o_resistor_adc_error   // Converter not finished.
);
  logic [`FMRD_DATA_W-1:0] mask_gen_q;   // General fault masks and trip action.
  logic [`FMRD_DATA_W-1:0] mask_led_q;   // Per-LED fault mask.
  logic [`FMRD_DATA_W-1:0] rdata_q;      // Read data register.
  logic                    fault_n_q;    // Fault pin register.
  logic [N_LED-1:0]        sw_q;         // Switch drive register.
  logic [3:0]              ident_q;      // Identity register.
  logic                    open_sum_q;   // Open summary register.
  logic                    short_sum_q;  // Short summary register.
  logic                    adc_err_q;    // Converter error register.

  logic [4:0] dec_status;  // Captured decode flags.
  logic [3:0] dec_addr;    // Captured address code.
  logic [3:0] dec_grade;   // Captured grade code.
  logic       adc_err;     // Converter still busy.
  logic       open_any;    // Unmasked open summary.
  logic       short_any;   // Unmasked short summary.
  logic       open_unmsk;  // Open through the LED mask.
  logic       short_unmsk; // Short through the LED mask.

  // Address decode as named wires.
  wire sel_gen  = (i_reg_addr == `FMRD_OFF_MASK_GEN);
  wire sel_led  = (i_reg_addr == `FMRD_OFF_MASK_LED);
  wire sel_stat = (i_reg_addr == `FMRD_OFF_DEC_STATUS);
  wire sel_code = (i_reg_addr == `FMRD_OFF_DEC_CODES);

  // Mask bit taps.
  wire msk_warn   = mask_gen_q[`FMRD_BIT_THERM_WARN];
  wire msk_adc    = mask_gen_q[`FMRD_BIT_ADC_ERR];
  wire msk_pump   = mask_gen_q[`FMRD_BIT_PUMP];
  wire msk_short  = mask_gen_q[`FMRD_BIT_SHORT];
  wire msk_open   = mask_gen_q[`FMRD_BIT_OPEN];
  wire msk_serial = mask_gen_q[`FMRD_BIT_SERIAL];
  wire trip_act   = mask_gen_q[`FMRD_BIT_TRIP_ACT];

  // Each source is gated only on its way to the pin, never in status.
  wire flt_warn   = i_thermal_warning & ~msk_warn;
  wire flt_adc    = adc_err & ~msk_adc;
  wire flt_pump   = i_pump_not_ready & ~msk_pump;
  wire flt_short  = short_unmsk & ~msk_short;
  wire flt_open   = open_unmsk & ~msk_open;
  wire flt_serial = i_serial_error & ~msk_serial;
  // The shutdown flag always reaches the pin; it has no mask bit.
  wire fault_any  = flt_warn | flt_adc | flt_pump | flt_short |
                    flt_open | flt_serial | i_thermal_trip;

  // A trip overrides every switch with the same chosen state.
  wire [N_LED-1:0] sw_d = i_thermal_trip ? {N_LED{~trip_act}} : i_switch_cmd;

  // Read mux; unmapped addresses and reserved bits read zero.
  wire [`FMRD_DATA_W-1:0] code_word =
    `FMRD_DATA_W'({dec_addr, dec_grade});
  wire [`FMRD_DATA_W-1:0] rdata_d =
    sel_gen  ? mask_gen_q :
    sel_led  ? mask_led_q :
    sel_stat ? `FMRD_DATA_W'(dec_status) :
    sel_code ? code_word : '0;

  fmrd_led_fault_gate #(
    .N_LED (N_LED)
  ) u_led_gate (
    .i_open_stat   (i_per_led_open),
    .i_short_stat  (i_per_led_short),
    .i_led_mask    (mask_led_q[N_LED-1:0]),
    .o_open_any    (open_any),
    .o_short_any   (short_any),
    .o_open_unmsk  (open_unmsk),
    .o_short_unmsk (short_unmsk)
  );

  fmrd_decode_capture u_decode (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_addr_valid  (i_addr_valid),
    .i_addr_code   (i_addr_code),
    .i_addr_high   (i_addr_high),
    .i_addr_low    (i_addr_low),
    .i_grade_valid (i_grade_valid),
    .i_grade_code  (i_grade_code),
    .i_grade_high  (i_grade_high),
    .i_grade_low   (i_grade_low),
    .o_status      (dec_status),
    .o_addr        (dec_addr),
    .o_grade       (dec_grade),
    .o_adc_error   (adc_err)
  );

  // Writable registers; only documented bits are stored.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_gen_q <= `FMRD_RST_MASK_GEN;
      mask_led_q <= `FMRD_RST_MASK_LED;
    end else if (i_reg_wr) begin
      if (sel_gen) mask_gen_q <= i_reg_wdata & `FMRD_MASK_GEN_WMASK;
      if (sel_led) mask_led_q <= `FMRD_DATA_W'(i_reg_wdata[N_LED-1:0]);
    end
  end

  // Read data is held until the next read strobe.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) rdata_q <= '0;
    else if (i_reg_rd) rdata_q <= rdata_d;
  end

  // Pin and status outputs, all registered. The pin is released in reset
  // so the host never sees a false fault during power-up.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fault_n_q   <= 1'b1;
      sw_q        <= '0;
      ident_q     <= `FMRD_RST_CODE;
      open_sum_q  <= 1'b0;
      short_sum_q <= 1'b0;
      adc_err_q   <= 1'b1;
    end else begin
      fault_n_q   <= ~fault_any;
      sw_q        <= sw_d;
      ident_q     <= dec_addr;
      open_sum_q  <= open_any;
      short_sum_q <= short_any;
      adc_err_q   <= adc_err;
    end
  end

  assign o_reg_rdata           = rdata_q;
  assign o_fault_out_n         = fault_n_q;
  assign o_switch_closed       = sw_q;
  assign o_node_identity       = ident_q;
  assign o_open_fault_summary  = open_sum_q;
  assign o_short_fault_summary = short_sum_q;
  assign o_resistor_adc_error  = adc_err_q;

  // Trip with the action bit clear closes every switch.
  sequence trip_close_s;
    i_thermal_trip && !trip_act;
  endsequence

  // Trip with the action bit set opens every switch.
  sequence trip_open_s;
    i_thermal_trip && trip_act;
  endsequence

  // An unmasked warning pulls the pin low.
  fault_warn_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_thermal_warning && !msk_warn)
    |=> !o_fault_out_n)
    else $error("Unmasked thermal warning did not assert fault pin.");

  // No unmasked cause: the pin is released.
  fault_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !fault_any
    |=> o_fault_out_n)
    else $error("Fault pin low with no unmasked cause.");

  // An unmasked serial error faults the pin.
  serial_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_serial_error && !msk_serial)
    |=> !o_fault_out_n)
    else $error("Unmasked serial error did not assert fault pin.");

  // A masked open alone leaves the pin high.
  open_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (msk_open && !flt_warn && !flt_adc && !flt_pump && !flt_short && !flt_serial && !i_thermal_trip)
    |=> o_fault_out_n)
    else $error("Masked open fault reached fault pin.");

  // An unmasked short faults the pin.
  short_pass_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (|(i_per_led_short & ~mask_led_q[N_LED-1:0]) && !msk_short)
    |=> !o_fault_out_n)
    else $error("Unmasked short did not assert fault pin.");

  // Pump not ready, unmasked, faults the pin.
  pump_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_pump_not_ready && !msk_pump)
    |=> !o_fault_out_n)
    else $error("Pump not ready did not assert fault pin.");

  // A busy converter, unmasked, faults the pin.
  adc_err_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (adc_err && !msk_adc)
    |=> !o_fault_out_n)
    else $error("Converter error did not assert fault pin.");

  // Switches take the chosen trip action.
  trip_close_a: assert property (@(posedge i_clk) disable iff (i_rst)
    trip_close_s
    |=> (o_switch_closed == {N_LED{1'b1}}))
    else $error("Trip with action clear left a switch open.");

  trip_open_a: assert property (@(posedge i_clk) disable iff (i_rst)
    trip_open_s
    |=> (o_switch_closed == '0))
    else $error("Trip with action set left a switch closed.");

  // Any open_fault_summary raises the summary.
  open_sum_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (|i_per_led_open)
    |=> o_open_fault_summary)
    else $error("Open summary missed an open_fault_summary.");

  // Done is set in the same cycle as the error falls.
  grade_done_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(adc_err)
    |-> dec_status[`FMRD_BIT_DONE] ##1 !o_resistor_adc_error)
    else $error("Converter error fell without done.");

  // Identity copies the captured address.
  ident_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ##1 (o_node_identity == $past(dec_addr)))
    else $error("Identity does not follow address code.");

  // A trip always faults the pin.
  trip_pin_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_thermal_trip
    |=> !o_fault_out_n)
    else $error("Trip left fault pin high.");

  // No trip: switches copy the request.
  sw_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_thermal_trip
    |=> (o_switch_closed == $past(i_switch_cmd)))
    else $error("Switches ignored request.");

  // An unmasked open faults the pin.
  open_pass_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (|(i_per_led_open & ~mask_led_q[N_LED-1:0]) && !msk_open)
    |=> !o_fault_out_n)
    else $error("Unmasked open left fault pin high.");

  // A masked short alone leaves the pin high.
  short_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (msk_short && !flt_warn && !flt_adc && !flt_pump && !flt_open && !flt_serial && !i_thermal_trip)
    |=> o_fault_out_n)
    else $error("Masked short reached fault pin.");

  // A masked warning alone leaves the pin high.
  warn_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (msk_warn && !flt_adc && !flt_pump && !flt_short && !flt_open && !flt_serial && !i_thermal_trip)
    |=> o_fault_out_n)
    else $error("Masked warning reached fault pin.");

  // A masked serial error alone leaves the pin high.
  serial_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (msk_serial && !flt_warn && !flt_adc && !flt_pump && !flt_short && !flt_open && !i_thermal_trip)
    |=> o_fault_out_n)
    else $error("Masked serial error reached fault pin.");

  // Any short_fault_summary raises the summary.
  short_sum_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (|i_per_led_short)
    |=> o_short_fault_summary)
    else $error("Short summary missed a short_fault_summary.");

  // No open_fault_summary: the summary is low.
  open_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !(|i_per_led_open)
    |=> !o_open_fault_summary)
    else $error("Open summary high with no open_fault_summary.");

  // A status read returns the decode flags.
  stat_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_reg_rd && sel_stat)
    |=> (o_reg_rdata == {8'h00, $past(dec_status)}))
    else $error("Status read returned wrong flags.");

  // A code read returns address then grade.
  code_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_reg_rd && sel_code)
    |=> (o_reg_rdata == {5'h00, $past(dec_addr), $past(dec_grade)}))
    else $error("Code read returned wrong codes.");

  // Done stays set until reset.
  done_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    dec_status[`FMRD_BIT_DONE]
    |=> dec_status[`FMRD_BIT_DONE])
    else $error("Done flag dropped.");

  // The error is low only once done.
  adc_done_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !adc_err
    |-> dec_status[`FMRD_BIT_DONE])
    else $error("Converter error low before done.");
endmodule // fmrd_fault_mask
`default_nettype wire

// ### fmrd_defines.svh
`ifndef FMRD_DEFINES_SVH
`define FMRD_DEFINES_SVH

// Register offsets on the internal register port.
`define FMRD_ADDR_W           7
`define FMRD_OFF_MASK_GEN     7'h0C
`define FMRD_OFF_MASK_LED     7'h0D
`define FMRD_OFF_DEC_STATUS   7'h0E
`define FMRD_OFF_DEC_CODES    7'h0F

// Register data width and reset values.
`define FMRD_DATA_W           13
`define FMRD_RST_MASK_GEN     13'h0000
`define FMRD_RST_MASK_LED     13'h0000
`define FMRD_RST_DEC_STATUS   5'h00
`define FMRD_RST_CODE         4'h0

// Field positions in the general mask register.
`define FMRD_BIT_THERM_WARN   0
`define FMRD_BIT_ADC_ERR      1
`define FMRD_BIT_PUMP         2
`define FMRD_BIT_SHORT        3
`define FMRD_BIT_OPEN         4
`define FMRD_BIT_SERIAL       6
`define FMRD_BIT_TRIP_ACT     12

// Writable bits of the general mask register; the rest read as zero.
`define FMRD_MASK_GEN_WMASK   13'h105F

// Field positions in the decode status and code registers.
`define FMRD_BIT_GRADE_LOW    0
`define FMRD_BIT_ADDR_LOW     1
`define FMRD_BIT_GRADE_HIGH   2
`define FMRD_BIT_ADDR_HIGH    3
`define FMRD_BIT_DONE         4
`define FMRD_CODE_GRADE_LSB   0
`define FMRD_CODE_ADDR_LSB    4

`endif

// ### fmrd_pkg.sv
`default_nettype none
package fmrd_pkg;
  // Capture state of the resistor decode results.
  typedef enum logic [2:0] {
    FMRD_DEC_WAIT  = 3'b001,
    FMRD_DEC_GRADE = 3'b010,
    FMRD_DEC_DONE  = 3'b100
  } fmrd_dec_state_t;
endpackage
`default_nettype wire

// ### fmrd_led_fault_gate.sv
`timescale 1ns/1ns
`default_nettype none
// Folds per-LED open and short status through the per-LED mask.
module fmrd_led_fault_gate #(
  parameter int N_LED = 12
) (
  input  wire logic [N_LED-1:0] i_open_stat,   // Per-LED open status.
  input  wire logic [N_LED-1:0] i_short_stat,  // Per-LED short status.
  input  wire logic [N_LED-1:0] i_led_mask,    // Per-LED fault mask.
  output logic                  o_open_any,    // Any LED open, unmasked.
  output logic                  o_short_any,   // Any LED short, unmasked.
  output logic                  o_open_unmsk,  // Open fault passing the LED mask.
  output logic                  o_short_unmsk  // Short fault passing the LED mask.
);
  logic [N_LED-1:0] open_pass;   // Opens from unmasked LEDs.
  logic [N_LED-1:0] short_pass;  // Shorts from unmasked LEDs.

  // One gate per LED; a set mask bit hides that LED from the pin only.
  for (genvar g = 0; g < N_LED; g++) begin : g_led
    assign open_pass[g]  = i_open_stat[g] & ~i_led_mask[g];
    assign short_pass[g] = i_short_stat[g] & ~i_led_mask[g];
  end

  // The summaries ignore the LED mask so the status stays readable.
  assign o_open_any    = |i_open_stat;
  assign o_short_any   = |i_short_stat;
  assign o_open_unmsk  = |open_pass;
  assign o_short_unmsk = |short_pass;
endmodule // fmrd_led_fault_gate
`default_nettype wire

// ### fmrd_decode_capture.sv
`timescale 1ns/1ns
`default_nettype none
`include "fmrd_defines.svh"
// Holds the resistor-sense converter results once each read completes.
module fmrd_decode_capture
  import fmrd_pkg::*;
(
  input  wire logic       i_clk,         // System clock.
  input  wire logic       i_rst,         // Asynchronous reset, active high.
  input  wire logic       i_addr_valid,  // Pulse: address read finished.
  input  wire logic [3:0] i_addr_code,   // Decoded address resistor.
  input  wire logic       i_addr_high,   // Address resistor above range or open.
  input  wire logic       i_addr_low,    // Address resistor below range or shorted.
  input  wire logic       i_grade_valid, // Pulse: grade read finished.
  input  wire logic [3:0] i_grade_code,  // Decoded grade resistor.
  input  wire logic       i_grade_high,  // Grade resistor above range or open.
  input  wire logic       i_grade_low,   // Grade resistor below range or shorted.
  output logic [4:0]      o_status,      // Done and range flags.
  output logic [3:0]      o_addr,        // Captured address code.
  output logic [3:0]      o_grade,       // Captured grade code.
  output logic            o_adc_error    // High until the grade read finishes.
);
  fmrd_dec_state_t state_q;   // Capture progress.
  fmrd_dec_state_t state_d;   // Next capture progress.
  logic [4:0]      status_q;  // Status flags.
  logic [3:0]      addr_q;    // Address code.
  logic [3:0]      grade_q;   // Grade code.

  // Address must arrive first; a grade pulse before it is ignored; grade completion ends the sequence.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FMRD_DEC_WAIT:  if (i_addr_valid) state_d = FMRD_DEC_GRADE;
      FMRD_DEC_GRADE: if (i_grade_valid) state_d = FMRD_DEC_DONE;
      FMRD_DEC_DONE:  state_d = FMRD_DEC_DONE;
      default:        state_d = FMRD_DEC_WAIT;
    endcase
  end

  // Results are latched once; later pulses cannot disturb the identity.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q  <= FMRD_DEC_WAIT;
      status_q <= `FMRD_RST_DEC_STATUS;
      addr_q   <= `FMRD_RST_CODE;
      grade_q  <= `FMRD_RST_CODE;
    end else begin
      state_q <= state_d;
      if (state_q == FMRD_DEC_WAIT && i_addr_valid) begin
        addr_q                        <= i_addr_code;
        status_q[`FMRD_BIT_ADDR_HIGH] <= i_addr_high;
        status_q[`FMRD_BIT_ADDR_LOW]  <= i_addr_low;
      end
      if (state_q == FMRD_DEC_GRADE && i_grade_valid) begin
        grade_q                        <= i_grade_code;
        status_q[`FMRD_BIT_GRADE_HIGH] <= i_grade_high;
        status_q[`FMRD_BIT_GRADE_LOW]  <= i_grade_low;
        status_q[`FMRD_BIT_DONE]       <= 1'b1;
      end
    end
  end

  assign o_status    = status_q;
  assign o_addr      = addr_q;
  assign o_grade     = grade_q;
  assign o_adc_error = (state_q != FMRD_DEC_DONE);
endmodule // fmrd_decode_capture
`default_nettype wire

// ### fmrd_host_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "fmrd_defines.svh"
// Host side of the register port: one strobe per access, launched on the falling edge.
module fmrd_host_model (
  input  wire logic                    i_clk,    // System clock.
  input  wire logic [`FMRD_DATA_W-1:0] i_rdata,  // Read data from the device.
  output logic                         o_wr,     // Write strobe.
  output logic                         o_rd,     // Read strobe.
  output logic [`FMRD_ADDR_W-1:0]      o_addr,   // Register address.
  output logic [`FMRD_DATA_W-1:0]      o_wdata   // Write data.
);
  // Strobes start low so nothing is taken while reset is held.
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 7'h7F;
    o_wdata = 13'h1FFF;
  end
  // One write; address and data are scrambled once the strobe drops so stale values never look valid.
  task automatic wr(input logic [6:0] a, input logic [12:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  // One read; the data is registered on the taking edge, so it is settled by the next falling edge.
  task automatic rd(input logic [6:0] a, output logic [12:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask
endmodule // fmrd_host_model
`default_nettype wire

// ### tb_fault_mask_and_resistor_decode.sv
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the fault mask and resistor decode register block.
module tb_fault_mask_and_resistor_decode;
  logic i_clk, i_rst, i_tw, i_tt, i_pn, i_se;          // Clock, reset and single status levels.
  logic [11:0] i_po, i_ps, i_sw;                       // Per-LED status and switch request.
  logic i_av, i_ah, i_al, i_gv, i_gh, i_gl;            // Converter result strobes and flags.
  logic [3:0] i_ac, i_gc;                              // Converter result codes.
  wire logic w_wr, w_rd;                               // Register strobes from the host.
  wire logic [6:0] w_addr;                             // Register address from the host.
  wire logic [12:0] w_wdata, o_rdata;                  // Write and read data.
  wire logic o_flt_n, o_osum, o_ssum, o_aerr;          // Fault pin, summaries, converter error.
  wire logic [11:0] o_sw;                              // Switch drive.
  wire logic [3:0] o_id;                               // Node identity.
  int n_mismatch, compares, cyc;                       // Mismatches, comparisons, cycle count.
  logic [12:0] rv;                                     // Last read value.
  int srcs[5] = '{0, 2, 3, 4, 6};                      // Masked sources by mask bit.

  fmrd_host_model host (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(w_wr), .o_rd(w_rd), .o_addr(w_addr),
    .o_wdata(w_wdata));
  fmrd_fault_mask #(.N_LED(12)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(w_wr), .i_reg_rd(w_rd),
    .i_reg_addr(w_addr), .i_reg_wdata(w_wdata), .i_thermal_warning(i_tw), .i_thermal_trip(i_tt),
    .i_pump_not_ready(i_pn), .i_serial_error(i_se), .i_per_led_open(i_po), .i_per_led_short(i_ps),
    .i_switch_cmd(i_sw), .i_addr_valid(i_av), .i_addr_code(i_ac), .i_addr_high(i_ah), .i_addr_low(i_al),
    .i_grade_valid(i_gv), .i_grade_code(i_gc), .i_grade_high(i_gh), .i_grade_low(i_gl),
    .o_reg_rdata(o_rdata), .o_fault_out_n(o_flt_n), .o_switch_closed(o_sw), .o_node_identity(o_id),
    .o_open_fault_summary(o_osum), .o_short_fault_summary(o_ssum), .o_resistor_adc_error(o_aerr));

  // Free-running 50 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Compares one value with case inequality so an unknown never passes.
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Reads a register and compares it.
  task automatic rchk(input logic [6:0] a, input logic [12:0] e);
    host.rd(a, rv);
    chk($sformatf("reg %h", a), e, rv);
  endtask

  // Lets the registered outputs follow a change of the status levels.
  task automatic settle();
    repeat (2) @(negedge i_clk);
  endtask

  // Holds reset for 12 cycles; masks and captures return to their reset values.
  task automatic do_reset();
    @(negedge i_clk);
    i_rst = 1'b1;
    repeat (12) @(negedge i_clk);
    i_rst = 1'b0;
  endtask

  // One converter strobe; the code and flags are scrambled once it drops.
  task automatic pulse(input logic grade, input logic [3:0] c, input logic hi, input logic lo);
    @(negedge i_clk);
    if (grade) {i_gv, i_gc, i_gh, i_gl} = {1'b1, c, hi, lo};
    else {i_av, i_ac, i_ah, i_al} = {1'b1, c, hi, lo};
    @(negedge i_clk);
    {i_av, i_gv, i_ac, i_gc, i_ah, i_al, i_gh, i_gl} = {2'b00, ~c, ~c, ~hi, ~lo, ~hi, ~lo};
  endtask

  // Drives one fault source selected by its mask bit position.
  task automatic set_src(input int k, input logic v);
    case (k)
      0: i_tw = v;
      2: i_pn = v;
      3: i_ps = v ? 12'h800 : 12'h000;
      4: i_po = v ? 12'h001 : 12'h000;
      6: i_se = v;
      default: ;
    endcase
  endtask

  // Cuts a hang short; the tests need well under this many cycles.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    {i_rst, i_tw, i_tt, i_pn, i_se, i_po, i_ps, i_sw} = {1'b1, 4'h0, 12'h000, 12'h000, 12'hA5A};
    {i_av, i_ah, i_al, i_gv, i_gh, i_gl, i_ac, i_gc} = {6'h00, 4'hF, 4'hF};
    do_reset();
    settle();
    chk("flt_n adc_err", 13'h0000, {12'h000, o_flt_n});
    foreach (srcs[j]) rchk(7'h0C + 7'(j % 4), 13'h0000);
    rchk(7'h00, 13'h0000);
    host.wr(7'h0C, 13'h0002);
    settle();
    chk("flt_n adc_msk", 13'h0001, {12'h000, o_flt_n});
    chk("adc_err seen", 13'h0001, {12'h000, o_aerr});
    host.wr(7'h0C, 13'h1FFF);
    rchk(7'h0C, 13'h105F);
    host.wr(7'h0D, 13'h1FFF);
    rchk(7'h0D, 13'h0FFF);
    host.wr(7'h0E, 13'h1FFF);
    rchk(7'h0E, 13'h0000);
    // Two captures, each after a fresh reset, so every range flag is seen set and clear.
    for (int c = 0; c < 2; c++) begin
      do_reset();
      pulse(1'b1, 4'h9, 1'b1, 1'b1);
      rchk(7'h0E, 13'h0000);
      chk("adc_err early", 13'h0001, {12'h000, o_aerr});
      pulse(1'b0, c ? 4'h3 : 4'hA, c == 0, c == 1);
      pulse(1'b1, c ? 4'hC : 4'h5, c == 1, c == 0);
      pulse(1'b0, 4'h7, 1'b0, 1'b0);
      rchk(7'h0E, {8'h00, 1'b1, c == 0, c == 1, c == 1, c == 0});
      rchk(7'h0F, c ? 13'h003C : 13'h00A5);
      chk("identity", c ? 13'h0003 : 13'h000A, {9'h000, o_id});
      chk("adc_err done", 13'h0000, {12'h000, o_aerr});
    end
    settle();
    chk("flt_n idle", 13'h0001, {12'h000, o_flt_n});
    chk("switch normal", 13'h0A5A, {1'b0, o_sw});
    // Each source faults the pin alone, and its mask bit hides it from the pin only.
    foreach (srcs[j]) begin
      set_src(srcs[j], 1'b1);
      settle();
      chk("flt_n src", 13'h0000, {12'h000, o_flt_n});
      host.wr(7'h0C, 13'h0001 << srcs[j]);
      settle();
      chk("flt_n masked", 13'h0001, {12'h000, o_flt_n});
      chk("summaries", {11'h000, srcs[j] == 4, srcs[j] == 3}, {11'h000, o_osum, o_ssum});
      set_src(srcs[j], 1'b0);
      host.wr(7'h0C, 13'h0000);
    end
    // The per-LED mask hides only the LEDs whose bit is set.
    host.wr(7'h0D, 13'h0020);
    i_po = 12'h020;
    settle();
    chk("led masked", 13'h0001, {12'h000, o_flt_n});
    chk("open sum", 13'h0001, {12'h000, o_osum});
    i_ps = 12'h040;
    settle();
    chk("led unmasked", 13'h0000, {12'h000, o_flt_n});
    {i_po, i_ps} = 24'h000000;
    settle();
    chk("open sum clr", 13'h0000, {11'h000, o_osum, o_ssum});
    // Thermal trip forces every switch closed, or open when the action bit is set.
    i_tt = 1'b1;
    settle();
    chk("trip close", 13'h0FFF, {1'b0, o_sw});
    chk("trip flt_n", 13'h0000, {12'h000, o_flt_n});
    host.wr(7'h0C, 13'h1000);
    settle();
    chk("trip open", 13'h0000, {1'b0, o_sw});
    i_tt = 1'b0;
    settle();
    chk("switch back", 13'h0A5A, {1'b0, o_sw});
    wrap_up();
  end
endmodule // tb_fault_mask_and_resistor_decode
`default_nettype wire
